// ===== core/lsc_mpls_comparator.sv
// Chosen here: register access over APB and the placing of the registers.
`timescale 1ns/1ps
module lsc_mpls_comparator (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [lsc_pkg::APB_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire lsc_pkg::lsc_word_in_t wordIn,
    output lsc_pkg::lsc_result_t result
);
    import lsc_pkg::*;

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!nrst);

    lsc_state_t state_r;
    lsc_label_t lbl;
    logic [LABEL_W-1:0] lbl_r [MAX_DEPTH];
    logic [DEPTH_W-1:0] depth_r;
    logic [CHAN_W-1:0] chan_r;
    logic bad_r;
    logic [31:0] cw_r;
    lsc_ctrl_t ctrl_r;
    lsc_flow_cfg_t cfg_r [NUM_FLOWS];
    logic [LABEL_W-1:0] lo_r [NUM_FLOWS][NUM_SETS];
    logic [LABEL_W-1:0] hi_r [NUM_FLOWS][NUM_SETS];
    logic [NUM_FLOWS-1:0] hit;
    logic [2:0] selIdx;
    logic selGrp;
    logic selCw;
    lsc_result_t res_r;
    logic [31:0] prdata_r;
    logic [31:0] rdata;
    logic [APB_AW-1:0] flowOff;
    logic [FLOW_SH-1:0] fo;
    logic [FLOW_SH-1:0] bo;
    logic [2:0] fIdx;
    logic [1:0] bSet;
    logic bHigh;
    logic inFlow;
    logic isCfg;
    logic isBnd;
    logic addrOk;
    logic wr;

    assign lbl = lsc_label_t'(wordIn.word);

    // stack walk
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            state_r <= ST_IDLE;
        end else if (ce) begin
            case (state_r)
                ST_IDLE: begin
                    if (wordIn.valid && wordIn.start) begin
                        state_r <= lbl.bos ? ST_CWORD : ST_LABEL;
                    end
                end
                ST_LABEL: begin
                    if (wordIn.valid) begin
                        if (lbl.bos) begin
                            state_r <= ST_CWORD;
                        end else if (depth_r == DEPTH_W'(MAX_DEPTH - 1)) begin
                            state_r <= ST_EVAL;
                        end
                    end
                end
                ST_CWORD: begin
                    if (wordIn.valid) begin
                        state_r <= ST_EVAL;
                    end
                end
                ST_EVAL: begin
                    state_r <= ST_IDLE;
                end
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

    // label capture, one 20-bit entry per label
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            depth_r <= '0;
            chan_r <= '0;
            bad_r <= 1'b0;
            cw_r <= '0;
            for (int i = 0; i < MAX_DEPTH; i++) begin
                lbl_r[i] <= '0;
            end
        end else if (ce) begin
            if (state_r == ST_IDLE && wordIn.valid && wordIn.start) begin
                lbl_r[0] <= lbl.value;
                depth_r <= DEPTH_W'(1);
                chan_r <= wordIn.chan;
                bad_r <= 1'b0;
            end else if (state_r == ST_LABEL && wordIn.valid) begin
                lbl_r[depth_r[1:0]] <= lbl.value;
                depth_r <= DEPTH_W'(depth_r + 1'b1);
                bad_r <= !lbl.bos && depth_r == DEPTH_W'(MAX_DEPTH - 1);
            end else if (state_r == ST_CWORD && wordIn.valid) begin
                cw_r <= wordIn.word;
            end
        end
    end

    deep_stack_a:
        assert property (ce && state_r == ST_LABEL && wordIn.valid && !lbl.bos
                && depth_r == DEPTH_W'(MAX_DEPTH - 1) |=> state_r == ST_EVAL && bad_r && hit == '0)
            else $error("over-deep stack not refused");
    bottom_step_a:
        assert property (ce && state_r == ST_LABEL && wordIn.valid && lbl.bos
                |=> state_r == ST_CWORD && depth_r == DEPTH_W'($past(depth_r) + 1'b1))
            else $error("bottom label did not close the stack");
    cw_take_a:
        assert property (ce && state_r == ST_CWORD && wordIn.valid
                |=> state_r == ST_EVAL && cw_r == $past(wordIn.word))
            else $error("word after stack not taken");

    // per-flow match
    for (genvar f = 0; f < NUM_FLOWS; f++) begin : g_flow
        logic fHit;
        always_comb begin
            logic [DEPTH_W-1:0] pos;
            pos = '0;
            fHit = cfg_r[f].enable && cfg_r[f].chanMask[chan_r] && !bad_r
                && depth_r != '0 && cfg_r[f].depthMask[2'(depth_r - 1'b1)];
            if (cfg_r[f].ctlWord && cw_r[CW_NIB_MSB -: CW_NIB_W] != '0) begin
                fHit = 1'b0;
            end
            for (int i = 0; i < NUM_SETS; i++) begin
                // end reference: i + depth - 4, wraps in the low two bits
                pos = cfg_r[f].refEnd ? DEPTH_W'(i) + depth_r : DEPTH_W'(i);
                if (cfg_r[f].refEnd ? pos >= DEPTH_W'(MAX_DEPTH) : pos < depth_r) begin
                    if (lbl_r[pos[1:0]] < lo_r[f][i] || lbl_r[pos[1:0]] > hi_r[f][i]) begin
                        fHit = 1'b0;
                    end
                end
            end
        end
        assign hit[f] = fHit;

        flow_off_a:
            assert property (!cfg_r[f].enable |-> !hit[f])
                else $error("disabled flow reported a match");
        chan_gate_a:
            assert property (hit[f] |-> cfg_r[f].chanMask[chan_r])
                else $error("match on masked-out channel");
        depth_gate_a:
            assert property (hit[f] |-> depth_r != '0 && depth_r <= DEPTH_W'(MAX_DEPTH)
                    && cfg_r[f].depthMask[2'(depth_r - 1'b1)])
                else $error("match on disallowed depth");
        cw_nibble_a:
            assert property (hit[f] && cfg_r[f].ctlWord |-> cw_r[CW_NIB_MSB -: CW_NIB_W] == '0)
                else $error("control word nibble not zero");
        top_range_a:
            assert property (hit[f] && !cfg_r[f].refEnd
                    |-> lbl_r[0] >= lo_r[f][0] && lbl_r[0] <= hi_r[f][0])
                else $error("top label outside set 0");
        end_range_a:
            assert property (hit[f] && cfg_r[f].refEnd |-> lbl_r[2'(depth_r - 1'b1)] >= lo_r[f][NUM_SETS-1]
                    && lbl_r[2'(depth_r - 1'b1)] <= hi_r[f][NUM_SETS-1])
                else $error("end label outside set 3");
    end

    // lowest matching flow names the next protocol
    always_comb begin
        logic found;
        found = 1'b0;
        selIdx = '0;
        selGrp = 1'b0;
        selCw = 1'b0;
        for (int f = 0; f < NUM_FLOWS; f++) begin
            if (hit[f] && !found) begin
                found = 1'b1;
                selIdx = 3'(f);
                selGrp = cfg_r[f].grpSel;
                selCw = cfg_r[f].ctlWord;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            res_r <= RESULT_RST;
        end else if (ce) begin
            res_r.valid <= state_r == ST_EVAL;
            if (state_r == ST_EVAL) begin
                res_r.flowMatch <= hit;
                res_r.depth <= depth_r;
                res_r.stackBad <= bad_r;
                res_r.flowIdx <= selIdx;
                res_r.nextComp <= selGrp ? ctrl_r.nextCompB : ctrl_r.nextCompA;
                res_r.nextOffset <= {depth_r, 2'b00} + (selCw ? CW_OCTETS : '0);
            end
        end
    end
    assign result = res_r;

    offset_calc_a:
        assert property (ce && state_r == ST_EVAL |=> res_r.valid && res_r.nextOffset
                == {$past(depth_r), 2'b00} + ($past(selCw) ? CW_OCTETS : '0))
            else $error("next-protocol offset wrong");
    group_pick_a:
        assert property (ce && state_r == ST_EVAL && hit != '0 |=> res_r.nextComp
                == ($past(selGrp) ? $past(ctrl_r.nextCompB) : $past(ctrl_r.nextCompA)))
            else $error("next comparator from wrong set");

    // apb decode
    always_comb begin
        flowOff = paddr - FLOW_BASE;
        fo = flowOff[FLOW_SH-1:0];
        bo = fo - BND_BASE;
        fIdx = flowOff[FLOW_SH+2:FLOW_SH];
        bSet = bo[4:3];
        bHigh = bo[2];
        inFlow = paddr >= FLOW_BASE && paddr < FLOW_END;
        isCfg = inFlow && fo == FLOW_CFG_OFF;
        isBnd = inFlow && fo >= BND_BASE && fo < BND_END && fo[1:0] == 2'b00;
        addrOk = paddr == ADDR_CTRL || paddr == ADDR_STATUS || isCfg || isBnd;
        rdata = '0;
        if (paddr == ADDR_CTRL) begin
            rdata[CTRL_W-1:0] = ctrl_r;
        end else if (paddr == ADDR_STATUS) begin
            rdata = {11'h000, res_r.nextOffset, 1'b0, res_r.nextComp, res_r.stackBad,
                     res_r.depth, res_r.flowMatch};
        end else if (isCfg) begin
            rdata[CFG_W-1:0] = cfg_r[fIdx];
        end else if (isBnd) begin
            rdata[LABEL_W-1:0] = bHigh ? hi_r[fIdx][bSet] : lo_r[fIdx][bSet];
        end
    end

    assign pready = ce;
    assign pslverr = psel && penable && !addrOk;
    assign wr = psel && penable && pwrite && ce && addrOk;
    assign prdata = prdata_r;

    // read data latched in the setup cycle
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            prdata_r <= '0;
        end else if (ce && psel && !penable) begin
            prdata_r <= rdata;
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            ctrl_r <= CTRL_RST;
            for (int f = 0; f < NUM_FLOWS; f++) begin
                cfg_r[f] <= FLOW_CFG_RST;
                for (int i = 0; i < NUM_SETS; i++) begin
                    lo_r[f][i] <= BOUND_LOW_RST;
                    hi_r[f][i] <= BOUND_HIGH_RST;
                end
            end
        end else if (wr) begin
            if (paddr == ADDR_CTRL) begin
                ctrl_r <= lsc_ctrl_t'(pwdata[CTRL_W-1:0]);
            end
            if (isCfg) begin
                cfg_r[fIdx] <= lsc_flow_cfg_t'(pwdata[CFG_W-1:0]);
            end
            if (isBnd && bHigh) begin
                hi_r[fIdx][bSet] <= pwdata[LABEL_W-1:0];
            end
            if (isBnd && !bHigh) begin
                lo_r[fIdx][bSet] <= pwdata[LABEL_W-1:0];
            end
        end
    end

    ctrl_write_a:
        assert property (wr && paddr == ADDR_CTRL |=> ctrl_r == $past(pwdata[CTRL_W-1:0]))
            else $error("shared control write lost");
endmodule

// ===== core/lsc_pkg.sv
package lsc_pkg;
    localparam int NUM_FLOWS = 8;
    localparam int NUM_CHAN = 4;
    localparam int NUM_SETS = 4;
    localparam int MAX_DEPTH = 4;
    localparam int LABEL_W = 20;
    localparam int DEPTH_W = 3;
    localparam int CHAN_W = 2;
    localparam int OFF_W = 5;
    localparam int APB_AW = 12;
    localparam int CW_NIB_MSB = 31;
    localparam int CW_NIB_W = 4;
    localparam int FLOW_SH = 6;
    localparam logic [OFF_W-1:0] CW_OCTETS = 5'h04;

    localparam logic [APB_AW-1:0] ADDR_CTRL = 12'h000;
    localparam logic [APB_AW-1:0] ADDR_STATUS = 12'h004;
    localparam logic [APB_AW-1:0] FLOW_BASE = 12'h100;
    localparam logic [APB_AW-1:0] FLOW_END = 12'h300;
    localparam logic [FLOW_SH-1:0] FLOW_CFG_OFF = 6'h00;
    localparam logic [FLOW_SH-1:0] BND_BASE = 6'h10;
    localparam logic [FLOW_SH-1:0] BND_END = 6'h30;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_LABEL = 2'b01,
        ST_CWORD = 2'b11,
        ST_EVAL = 2'b10
    } lsc_state_t;

    typedef struct packed {
        logic [LABEL_W-1:0] value;
        logic [2:0] tc;
        logic bos;
        logic [7:0] ttl;
    } lsc_label_t;

    typedef struct packed {
        logic [NUM_CHAN-1:0] chanMask;
        logic [MAX_DEPTH-1:0] depthMask;
        logic grpSel;
        logic refEnd;
        logic ctlWord;
        logic enable;
    } lsc_flow_cfg_t;

    typedef struct packed {
        logic [1:0] matchMode;
        logic [2:0] nextCompB;
        logic [2:0] nextCompA;
    } lsc_ctrl_t;

    typedef struct packed {
        logic valid;
        logic start;
        logic [CHAN_W-1:0] chan;
        logic [31:0] word;
    } lsc_word_in_t;

    typedef struct packed {
        logic valid;
        logic [NUM_FLOWS-1:0] flowMatch;
        logic [DEPTH_W-1:0] depth;
        logic stackBad;
        logic [2:0] flowIdx;
        logic [2:0] nextComp;
        logic [OFF_W-1:0] nextOffset;
    } lsc_result_t;

    localparam int CTRL_W = $bits(lsc_ctrl_t);
    localparam int CFG_W = $bits(lsc_flow_cfg_t);
    localparam lsc_ctrl_t CTRL_RST = '0;
    localparam lsc_flow_cfg_t FLOW_CFG_RST = '0;
    localparam logic [LABEL_W-1:0] BOUND_LOW_RST = 20'h00000;
    localparam logic [LABEL_W-1:0] BOUND_HIGH_RST = 20'hFFFFF;
    localparam lsc_result_t RESULT_RST = '0;
endpackage

// ===== test/lsc_stream_src.sv
`timescale 1ns/1ps
module lsc_stream_src (
    input wire logic mclk,
    input wire logic go,
    input wire logic gap,
    input wire logic [2:0] cnt,
    input wire logic [1:0] chan,
    input wire logic [159:0] words,
    output lsc_pkg::lsc_word_in_t wordIn
);
    import lsc_pkg::*;
    // one stack word per valid cycle; idle data never repeats the last word
    initial begin
        wordIn = '0;
        forever begin
            @(posedge mclk);
            if (go) begin
                for (int i = 0; i < int'(cnt); i++) begin
                    if (gap) begin
                        wordIn.valid <= 1'b0;
                        wordIn.word <= ~wordIn.word;
                        @(posedge mclk);
                    end
                    wordIn <= '{1'b1, i == 0, chan, words[32 * i +: 32]};
                    @(posedge mclk);
                end
                wordIn.valid <= 1'b0;
                wordIn.start <= 1'b0;
                wordIn.word <= ~wordIn.word;
            end
        end
    end
endmodule

// ===== test/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import lsc_pkg::*;
    logic mclk, nrst, ce, psel, penable, pwrite, go, gap, perr, pready, pslverr;
    logic [APB_AW-1:0] paddr;
    logic [31:0] pwdata, prdata, q;
    lsc_word_in_t wordIn;
    lsc_result_t result, e;
    logic [2:0] cnt, nA, nB;
    logic [1:0] chan;
    logic [159:0] words;
    logic [31:0] w [5];
    logic [11:0] cfg [8];
    logic [19:0] lo [8][4];
    logic [19:0] hi [8][4];
    int miscompares, check_count;

    lsc_mpls_comparator dut (.mclk(mclk), .nrst(nrst), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .wordIn(wordIn), .result(result));
    lsc_stream_src src (.mclk(mclk), .go(go), .gap(gap), .cnt(cnt), .chan(chan), .words(words),
        .wordIn(wordIn));

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    task automatic end_of_test();
        $display("checks %0d miscompares %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic check(input logic ok, input string msg);
        check_count++;
        if (ok !== 1'b1) begin
            miscompares++;
            $display("wrong value at %0t: %s", $time, msg);
        end
    endtask

    // apb transfer, entered just after a rising edge
    task automatic apb(input logic wr, input logic [APB_AW-1:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        q = prdata;
        perr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) begin
            miscompares++;
            end_of_test();
        end
        @(posedge mclk);
    endtask

    task automatic prog();
        apb(1'b1, ADDR_CTRL, {24'h0, 2'($urandom), nB, nA});
        for (int f = 0; f < 8; f++) begin
            apb(1'b1, FLOW_BASE + 12'(f * 64), {20'h0, cfg[f]});
            for (int i = 0; i < 4; i++) begin
                apb(1'b1, FLOW_BASE + 12'(f * 64 + 16 + 8 * i), {12'h0, lo[f][i]});
                apb(1'b1, FLOW_BASE + 12'(f * 64 + 20 + 8 * i), {12'h0, hi[f][i]});
            end
        end
    endtask

    function automatic lsc_result_t exp_res(input int d, input logic bad);
        lsc_result_t r;
        logic m;
        int k;
        r = '0;
        r.valid = 1'b1;
        r.depth = 3'(d);
        r.stackBad = bad;
        r.nextComp = nA;
        for (int f = 7; f >= 0; f--) begin
            m = cfg[f][0] && cfg[f][8 + chan] && cfg[f][3 + d] && !bad;
            if (cfg[f][1] && w[d][31:28] != 4'h0) m = 1'b0;
            for (int i = 0; i < 4; i++) begin
                k = cfg[f][2] ? d - 4 + i : i;
                if (k >= 0 && k < d && (w[k][31:12] < lo[f][i] || w[k][31:12] > hi[f][i])) m = 1'b0;
            end
            r.flowMatch[f] = m;
            if (m) begin
                r.flowIdx = 3'(f);
                r.nextComp = cfg[f][3] ? nB : nA;
                r.nextOffset = 5'(4 * d + (cfg[f][1] ? 4 : 0));
            end
        end
        return r;
    endfunction

    initial begin
        int d, n;
        logic bad;
        nrst = 1'b0;
        ce = 1'b1;
        {psel, penable, pwrite, paddr, pwdata, go, gap, cnt, chan, words} = '0;
        miscompares = 0;
        check_count = 0;
        void'($urandom(32'h5978));
        repeat (2) @(posedge mclk);
        nrst <= 1'b1;
        @(posedge mclk);
        apb(1'b0, ADDR_CTRL, 32'h0);
        check(q === 32'h0, "ctrl reset");
        apb(1'b0, 12'h2C0, 32'h0);
        check(q === 32'h0, "flow cfg reset");
        apb(1'b0, 12'h2D0, 32'h0);
        check(q === 32'h0, "bound low reset");
        apb(1'b0, 12'h2EC, 32'h0);
        check(q === 32'h000FFFFF, "bound high reset");
        apb(1'b1, 12'h008, 32'hFFFFFFFF);
        check(perr === 1'b1, "unmapped write");
        apb(1'b0, 12'h008, 32'h0);
        check(perr === 1'b1 && q === 32'h0, "unmapped read");
        apb(1'b1, ADDR_CTRL, 32'hFFFFFFFF);
        apb(1'b0, ADDR_CTRL, 32'h0);
        check(q === 32'h000000FF && perr === 1'b0, "ctrl width");
        for (int t = 0; t < 40; t++) begin
            nA = 3'($urandom);
            nB = 3'($urandom);
            for (int f = 0; f < 8; f++) begin
                cfg[f] = {4'($urandom), 4'($urandom), 3'($urandom), 1'($urandom % 4 != 0)};
                for (int i = 0; i < 4; i++) begin
                    lo[f][i] = 20'h10 + 20'($urandom % 3);
                    hi[f][i] = 20'h10 + 20'($urandom % 3);
                    if ($urandom % 4 == 0) begin
                        lo[f][i] = 20'h0;
                        hi[f][i] = 20'hFFFFF;
                    end
                end
            end
            prog();
            bad = (t % 7 == 3);
            d = bad ? 4 : 1 + int'($urandom % 4);
            cnt = bad ? 3'h4 : 3'(d + 1);
            chan = 2'($urandom);
            gap = 1'($urandom);
            for (int i = 0; i < 5; i++) begin
                w[i] = {20'h10 + 20'($urandom % 3), 3'($urandom), 1'(i == d - 1 && !bad), 8'($urandom)};
                words[32 * i +: 32] = w[i];
            end
            w[d][31:28] = ($urandom % 2) ? 4'h0 : 4'($urandom);
            words[32 * d +: 32] = w[d];
            e = exp_res(d, bad);
            go <= 1'b1;
            @(posedge mclk);
            go <= 1'b0;
            n = 0;
            do begin
                @(posedge mclk);
                #1;
                n++;
            end while (result.valid !== 1'b1 && n < 40);
            if (n >= 40) begin
                miscompares++;
                end_of_test();
            end
            check(result.flowMatch === e.flowMatch, "flow match");
            check({result.depth, result.stackBad} === {e.depth, e.stackBad}, "depth");
            check(result.nextComp === e.nextComp, "next comparator");
            if (|e.flowMatch) check({result.flowIdx, result.nextOffset} === {e.flowIdx, e.nextOffset}, "off");
            @(posedge mclk);
            apb(1'b0, ADDR_STATUS, 32'h0);
            check(q[14:0] === {e.nextComp, e.stackBad, e.depth, e.flowMatch}, "status");
        end
        // clock enable low stalls the bus and the result
        ce <= 1'b0;
        repeat (3) @(posedge mclk);
        check(pready === 1'b0 && result.valid === 1'b0, "frozen");
        ce <= 1'b1;
        nrst <= 1'b0;
        repeat (2) @(posedge mclk);
        nrst <= 1'b1;
        @(posedge mclk);
        apb(1'b0, ADDR_CTRL, 32'h0);
        check(q === 32'h0, "ctrl after reset");
        apb(1'b0, ADDR_STATUS, 32'h0);
        check(q === 32'h0, "status after reset");
        end_of_test();
    end
endmodule
